// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ubsm_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        data_pin_out, data_pin_oe, clock_pin_out, clock_pin_oe;
  logic        rx_drive, cpol;
  wire         data_pin_in;
  logic [15:0] v1, v2;
  int          fail_count, compares, n;

  assign data_pin_in = data_pin_oe ? data_pin_out : rx_drive;

  ubsm_top i_ubsm_top (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe), .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe)
  );

  ubsm_far_node #(.BIT(8)) i_ubsm_far_node (
    .pclk(pclk), .tx_line(clock_pin_out), .sync_data(data_pin_out), .cpol(cpol),
    .rx_drive(rx_drive)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until answered; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpol = 1'b0;
    fail_count = 0;
    compares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, clock_pin_out, clock_pin_oe, data_pin_oe}, 32'h4);
    rd_chk(UBSM_CTRL_OFF, 32'h0);
    rd_chk(UBSM_BAUD_OFF, 32'h1f);
    rd_chk(UBSM_STAT_OFF, 32'h3);
    rd_chk(UBSM_TXD_OFF, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(UBSM_BAUD_OFF, 32'h7);
    // Transmit refused without the enable
    wr(UBSM_CTRL_OFF, 32'h1);
    wr(UBSM_TXD_OFF, 32'h11);
    repeat (4) @(posedge pclk);
    rd_chk(UBSM_STAT_OFF, 32'h3);
    // Header: break then sync byte queued behind it
    wr(UBSM_CTRL_OFF, 32'h7);
    fork
      begin
        i_ubsm_far_node.get_frame(14, v1);
        i_ubsm_far_node.get_frame(10, v2);
      end
      begin
        wr(UBSM_TXD_OFF, 32'ha5);
        wr(UBSM_TXD_OFF, 32'h55);
        rd_chk(UBSM_STAT_OFF, 32'h0);
      end
    join
    chk({16'h0, v1}, 32'h2000);
    chk({16'h0, v2}, 32'h02aa);
    repeat (10) @(posedge pclk);
    rd_chk(UBSM_CTRL_OFF, 32'h3);
    rd_chk(UBSM_STAT_OFF, 32'h3);
    // Reception of a byte, then of a break
    wr(UBSM_CTRL_OFF, 32'h41);
    i_ubsm_far_node.send_frame(8'hc3, 1'b1);
    rd_chk(UBSM_STAT_OFF, 32'h7);
    rd_chk(UBSM_RXD_OFF, 32'hc3);
    rd_chk(UBSM_STAT_OFF, 32'h3);
    i_ubsm_far_node.send_frame(8'h00, 1'b0);
    apb(1'b0, UBSM_STAT_OFF, 32'h0);
    chk(r & 32'hc, 32'hc);
    rd_chk(UBSM_RXD_OFF, 32'h0);
    // Wake on falling edge, cleared by the rise, then a normal byte
    wr(UBSM_CTRL_OFF, 32'h341);
    fork
      i_ubsm_far_node.send_frame(8'h00, 1'b0);
      begin
        repeat (20) @(posedge pclk);
        apb(1'b0, UBSM_STAT_OFF, 32'h0);
        chk(r & 32'h4, 32'h4);
      end
    join
    rd_chk(UBSM_CTRL_OFF, 32'h241);
    apb(1'b0, UBSM_RXD_OFF, 32'h0);
    apb(1'b0, UBSM_STAT_OFF, 32'h0);
    chk(r & 32'h4, 32'h0);
    i_ubsm_far_node.send_frame(8'h3c, 1'b1);
    rd_chk(UBSM_STAT_OFF, 32'h7);
    rd_chk(UBSM_RXD_OFF, 32'h3c);
    // Sync master transmit, both clock polarities, two bytes back to back
    for (int p = 0; p < 2; p++) begin
      cpol <= p[0];
      wr(UBSM_CTRL_OFF, {24'h0, p[0], 7'h1b});
      repeat (4) @(posedge pclk);
      chk({29'h0, clock_pin_out, clock_pin_oe, data_pin_oe}, {29'h0, p[0], 2'b11});
      i_ubsm_far_node.clear_sync();
      wr(UBSM_TXD_OFF, 32'h96);
      wr(UBSM_TXD_OFF, 32'h5a);
      n = 0;
      do begin
        apb(1'b0, UBSM_STAT_OFF, 32'h0);
        n++;
      end while ((r & 32'h3) !== 32'h3 && n < 200);
      chk(r & 32'h3, 32'h3);
      repeat (40) @(posedge pclk);
      chk(i_ubsm_far_node.nlead, 32'd16);
      chk({16'h0, i_ubsm_far_node.sh}, 32'h5a96);
      chk({31'h0, clock_pin_out}, {31'h0, p[0]});
    end
    summarize();
  end
endmodule

// ===== test/ubsm_far_node.sv
`timescale 1ns/1ps
module ubsm_far_node #(
  parameter int BIT = 8
) (
  input  wire logic pclk,
  input  wire logic tx_line,
  input  wire logic sync_data,
  input  wire logic cpol,
  output logic      rx_drive
);
  int          nlead;
  logic [15:0] sh;
  logic        ck_q;

  initial begin
    rx_drive = 1'b1;
    ck_q     = 1'b1;
    nlead    = 0;
    sh       = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sync slave view: count leading edges, take data at trailing edges
  always @(posedge pclk) begin
    ck_q <= tx_line;
    if (tx_line !== ck_q && tx_line !== cpol) nlead <= nlead + 1;
    if (tx_line !== ck_q && tx_line === cpol) sh <= {sync_data, sh[15:1]};
  end

  task automatic clear_sync();
    @(posedge pclk);
    nlead <= 0;
    sh    <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Zero data with a low stop level makes a break on the line
  task automatic send_frame(input logic [7:0] b, input logic stopv);
    logic [9:0] f;
    f = {stopv, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rx_drive <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rx_drive <= 1'b1;
    repeat (2 * BIT) @(posedge pclk);
  endtask

  // Returns at mid stop bit so a frame queued right behind is not missed
  task automatic get_frame(input int n, output logic [15:0] v);
    v = '0;
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BIT) @(posedge pclk);
      v[i] = tx_line;
    end
  endtask
endmodule

// ===== verilog/ubsm_pkg.sv
// Behaviour
// - Break is start, twelve zeros, stop
// - Break write sends zeros, data ignored
// - Hardware clears break request after stop bit
// - Shift empty flag behaves as for characters
// - Buffer empty flag rises when holding empties
// - Received break: ready, framing error, 00h
// - Wake watches two edges, then receives byte
// - Synchronous mode: no start or stop bits
// - Master drives clock pin in sync mode
// - One clock per bit, change on lead
// - Polarity selects idle level and data edge
// - Sync transmit drives data and clock pins
// - Holding waits for shift register, else moves
// - Shift register is not software visible
// - Wake event is falling edge on data
// - Reading receive data clears ready flag
package ubsm_pkg;

  localparam logic [7:0] UBSM_CTRL_OFF = 8'h00;
  localparam logic [7:0] UBSM_STAT_OFF = 8'h04;
  localparam logic [7:0] UBSM_TXD_OFF  = 8'h08;
  localparam logic [7:0] UBSM_RXD_OFF  = 8'h0c;
  localparam logic [7:0] UBSM_BAUD_OFF = 8'h10;

  localparam int unsigned UBSM_CTRL_W = 10;

  typedef struct packed {
    logic autobaud_enable;
    logic wake_on_break_enable;
    logic clock_polarity_select;
    logic continuous_receive_enable;
    logic single_receive_enable;
    logic clock_source_master;
    logic clocked_mode_select;
    logic send_break_request;
    logic transmit_enable_bit;
    logic port_enable;
  } ubsm_ctrl_t;

  localparam ubsm_ctrl_t  UBSM_CTRL_RST  = '0;
  localparam logic [15:0] UBSM_BAUD_RST  = 16'h001f;
  localparam logic [3:0]  UBSM_LAST_DATA  = 4'h7;
  localparam logic [3:0]  UBSM_LAST_BREAK = 4'hb;
  localparam logic [3:0]  UBSM_RX_STOP    = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_START    = 3'b001,
    ST_DATA     = 3'b010,
    ST_STOP     = 3'b011,
    ST_CK_LEAD  = 3'b100,
    ST_CK_TRAIL = 3'b101
  } ubsm_state_t;

endpackage

// ===== verilog/ubsm_rx.sv
`timescale 1ns/1ps
module ubsm_rx
  import ubsm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        enable,
  input  wire logic        rx_in,
  input  wire logic [15:0] bit_div,
  output logic             byte_valid,
  output logic [7:0]       rx_byte,
  output logic             frame_err
);

  logic        busy;
  logic        armed;
  logic [15:0] cnt;
  logic [3:0]  idx;
  logic [7:0]  sh;

  wire sample = busy & (cnt == '0);
  wire start  = ~busy & armed & ~rx_in & enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      armed      <= 1'b0;
      cnt        <= '0;
      idx        <= '0;
      sh         <= '0;
      byte_valid <= 1'b0;
      rx_byte    <= '0;
      frame_err  <= 1'b0;
    end else if (ce) begin
      byte_valid <= 1'b0;
      // A held-low line must rise again before the next start bit
      if (!busy) armed <= rx_in;
      if (!enable) begin
        busy <= 1'b0;
      end else if (start) begin
        busy  <= 1'b1;
        armed <= 1'b0;
        idx   <= '0;
        cnt   <= bit_div >> 1;
      end else if (sample) begin
        cnt <= bit_div;
        idx <= 4'(idx + 4'h1);
        if (idx == '0 && rx_in) begin
          busy <= 1'b0;
        end else if (idx == UBSM_RX_STOP) begin
          busy       <= 1'b0;
          byte_valid <= 1'b1;
          rx_byte    <= sh;
          frame_err  <= ~rx_in;
        end else if (idx != '0) begin
          sh <= {rx_in, sh[7:1]};
        end
      end else if (busy) begin
        cnt <= cnt - 16'h0001;
      end
    end
  end

endmodule

// ===== verilog/ubsm_top.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ubsm_top
  import ubsm_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              data_pin_in,
  output logic                   data_pin_out,
  output logic                   data_pin_oe,
  output logic                   clock_pin_out,
  output logic                   clock_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode

  ubsm_ctrl_t  ctrl;
  ubsm_ctrl_t  next_ctrl;
  logic [15:0] baud_div;
  logic [15:0] baud_cnt;
  logic        hold_full;
  logic [7:0]  hold_data;
  logic        tx_buffer_empty;
  logic        rx_char_ready;
  logic        framing_error;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_framing_error_flag;
  logic        rx_s1;
  logic        rx_s2;
  logic        rx_s3;

  ubsm_state_t state;
  ubsm_state_t next_state;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [3:0]  bit_idx;
  logic [3:0]  next_idx;
  logic        is_break;
  logic        next_brk;
  logic        line;
  logic        next_line;
  logic        sck;
  logic        next_sck;
  logic        stop_done;

  wire [7:0] addr   = paddr[7:0];
  wire       acc    = psel & penable;
  wire       done   = acc & pready;
  wire       wr     = done & pwrite;
  wire       rd     = done & ~pwrite;
  // Shift register has no address
  wire       addr_ok = (addr == UBSM_CTRL_OFF) | (addr == UBSM_STAT_OFF) |
                       (addr == UBSM_TXD_OFF) | (addr == UBSM_RXD_OFF) |
                       (addr == UBSM_BAUD_OFF);

  wire async_mode = ~ctrl.clocked_mode_select;
  wire sync_master = ctrl.clocked_mode_select & ctrl.clock_source_master & ctrl.port_enable;
  wire sync_tx = sync_master & ~ctrl.single_receive_enable &
                 ~ctrl.continuous_receive_enable;
  wire tx_allowed = ctrl.port_enable & ctrl.transmit_enable_bit & (async_mode | sync_tx);

  wire wr_ctrl = wr & (addr == UBSM_CTRL_OFF);
  wire wr_tx   = wr & (addr == UBSM_TXD_OFF) & tx_allowed;
  wire wr_baud = wr & (addr == UBSM_BAUD_OFF);
  wire rd_rx   = rd & (addr == UBSM_RXD_OFF);

  wire shift_empty = (state == ST_IDLE);
  wire baud_tick   = (baud_cnt == '0);
  wire load        = shift_empty & hold_full & tx_allowed;
  wire cpol        = ctrl.clock_polarity_select;
  wire [3:0] last_bit = is_break ? UBSM_LAST_BREAK : UBSM_LAST_DATA;

  wire [31:0] status = {28'h0000000, framing_error, rx_char_ready,
                        tx_buffer_empty, shift_empty};
  wire [31:0] rd_mux = (addr == UBSM_CTRL_OFF) ? {22'h000000, ctrl} :
                       (addr == UBSM_STAT_OFF) ? status :
                       (addr == UBSM_RXD_OFF)  ? {24'h000000, rx_data} :
                       (addr == UBSM_BAUD_OFF) ? {16'h0000, baud_div} : 32'h00000000;

  // Wake watches the synchronised data line
  wire wake_arm  = ctrl.wake_on_break_enable & async_mode & ctrl.port_enable;
  wire wake_fall = wake_arm & rx_s3 & ~rx_s2;
  wire wake_rise = wake_arm & ~rx_s3 & rx_s2;
  wire rx_en     = ctrl.port_enable & async_mode & ctrl.continuous_receive_enable &
                   ~ctrl.wake_on_break_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= ~addr_ok;
      end
    end
  end

  // Software writes win over hardware clears in the same cycle
  always_comb begin
    next_ctrl = ctrl;
    if (stop_done & is_break) next_ctrl.send_break_request = 1'b0;
    if (wake_rise) next_ctrl.wake_on_break_enable = 1'b0;
    if (wr_ctrl) next_ctrl = ubsm_ctrl_t'(pwdata[UBSM_CTRL_W-1:0]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl            <= UBSM_CTRL_RST;
      baud_div        <= UBSM_BAUD_RST;
      hold_full       <= 1'b0;
      hold_data       <= '0;
      tx_buffer_empty <= 1'b1;
    end else if (ce) begin
      ctrl <= next_ctrl;
      if (wr_baud) baud_div <= pwdata[15:0];
      // Next byte may queue behind a break
      hold_full       <= (hold_full & ~load) | wr_tx;
      tx_buffer_empty <= ~((hold_full & ~load) | wr_tx);
      if (wr_tx) hold_data <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive side

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
    end else if (ce) begin
      rx_s1 <= data_pin_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  ubsm_rx i_ubsm_rx (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .enable     (rx_en),
    .rx_in      (rx_s2),
    .bit_div    (baud_div),
    .byte_valid (rx_valid),
    .rx_byte    (rx_byte),
    .frame_err  (rx_framing_error_flag)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_char_ready <= 1'b0;
      framing_error <= 1'b0;
      rx_data       <= '0;
    end else if (ce) begin
      rx_char_ready <= (rx_char_ready & ~rd_rx) | rx_valid | wake_fall;
      if (rx_valid) begin
        rx_data       <= rx_byte;
        framing_error <= rx_framing_error_flag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit engine, shared by asynchronous and clocked modes

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_idx   = bit_idx;
    next_line  = line;
    next_sck   = cpol;
    next_brk   = is_break;
    stop_done  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (!sync_tx) next_line = 1'b1;
        if (load) begin
          next_brk   = ctrl.send_break_request & async_mode;
          next_shreg = next_brk ? 8'h00 : hold_data;
          next_idx   = '0;
          if (sync_tx) begin
            // No framing bits in clocked mode
            next_state = ST_CK_LEAD;
            next_line  = hold_data[0];
            next_sck   = ~cpol;
          end else begin
            next_state = ST_START;
            next_line  = 1'b0;
          end
        end
      end
      ST_START: begin
        if (baud_tick) begin
          next_state = ST_DATA;
          next_line  = shreg[0];
        end
      end
      ST_DATA: begin
        if (baud_tick) begin
          if (bit_idx == last_bit) begin
            next_state = ST_STOP;
            next_line  = 1'b1;
          end else begin
            next_idx   = 4'(bit_idx + 4'h1);
            next_shreg = shreg >> 1;
            next_line  = shreg[1];
          end
        end
      end
      ST_STOP: begin
        if (baud_tick) begin
          next_state = ST_IDLE;
          stop_done  = 1'b1;
        end
      end
      ST_CK_LEAD: begin
        next_sck = ~cpol;
        if (baud_tick) next_state = ST_CK_TRAIL;
        if (baud_tick) next_sck = cpol;
      end
      ST_CK_TRAIL: begin
        if (baud_tick) begin
          if (bit_idx == UBSM_LAST_DATA) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_CK_LEAD;
            next_idx   = 4'(bit_idx + 4'h1);
            next_shreg = shreg >> 1;
            next_line  = shreg[1];
            next_sck   = ~cpol;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Disabling the port aborts a character in flight
    if (!ctrl.port_enable) next_state = ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      shreg    <= '0;
      bit_idx  <= '0;
      is_break <= 1'b0;
      line     <= 1'b1;
      sck      <= 1'b0;
      baud_cnt <= '0;
    end else if (ce) begin
      state    <= next_state;
      shreg    <= next_shreg;
      bit_idx  <= next_idx;
      is_break <= next_brk;
      line     <= next_line;
      sck      <= next_sck;
      // Restart on load so the first bit is full length
      baud_cnt <= (load | baud_tick) ? baud_div : baud_cnt - 16'h0001;
    end
  end

  // Async transmit leaves on the clock pin; clocked master transmit drives both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_pin_out <= 1'b1;
      clock_pin_oe  <= 1'b0;
      data_pin_out  <= 1'b1;
      data_pin_oe   <= 1'b0;
    end else if (ce) begin
      clock_pin_out <= sync_master ? sck : line;
      clock_pin_oe  <= ctrl.port_enable & (async_mode | ctrl.clock_source_master);
      data_pin_out  <= line;
      data_pin_oe   <= sync_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_break_len;
    (ce && state == ST_DATA && is_break && baud_tick && bit_idx == UBSM_LAST_BREAK)
      |=> (state == ST_STOP || !ctrl.port_enable);
  endproperty
  a_break_len: assert property (p_break_len) else $error("break length wrong");

  property p_break_zero;
    (state == ST_DATA && is_break) |-> (shreg == 8'h00 && !line);
  endproperty
  a_break_zero: assert property (p_break_zero) else $error("break not zeros");

  property p_break_clear;
    (ce && stop_done && is_break && !wr_ctrl) |=> !ctrl.send_break_request;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break request kept");

  property p_shift_busy;
    (ce && load && ctrl.port_enable) |=> !shift_empty;
  endproperty
  a_shift_busy: assert property (p_shift_busy) else $error("shift empty while busy");

  property p_hold_empty;
    (ce && load && !wr_tx) |=> tx_buffer_empty;
  endproperty
  a_hold_empty: assert property (p_hold_empty) else $error("buffer empty missing");

  property p_rx_break;
    (ce && rx_valid && rx_byte == 8'h00 && rx_framing_error_flag)
      |=> (rx_char_ready && framing_error && rx_data == 8'h00);
  endproperty
  a_rx_break: assert property (p_rx_break) else $error("break not reported");

  property p_wake;
    (ce && wake_fall) |=> rx_char_ready;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not flagged");

  property p_ck_oe;
    (ce && sync_master) |=> clock_pin_oe;
  endproperty
  a_ck_oe: assert property (p_ck_oe) else $error("clock driver off");

  property p_data_oe;
    (ce && sync_tx) |=> data_pin_oe;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data driver off");

  property p_sync_idle;
    (ce && sync_tx && state == ST_IDLE && !load) |=> (sck == $past(cpol));
  endproperty
  a_sync_idle: assert property (p_sync_idle) else $error("clock idle level");

  property p_lead;
    (ce && state == ST_CK_TRAIL && baud_tick && bit_idx != UBSM_LAST_DATA && ctrl.port_enable)
      |=> (state == ST_CK_LEAD && line == $past(shreg[1]) && sck != $past(cpol));
  endproperty
  a_lead: assert property (p_lead) else $error("lead edge data wrong");

  property p_queue;
    (ce && load && ctrl.port_enable) |=> (state != ST_IDLE) ##1 (state != ST_IDLE);
  endproperty
  a_queue: assert property (p_queue) else $error("holding not moved");

  property p_rd_clear;
    (ce && rd_rx && !rx_valid && !wake_fall) |=> !rx_char_ready;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("ready not cleared");

endmodule
